// ### logic/lsd_core.sv
/*
 led sink latch and fault status core: serial shift register, two latches,
 fault holders, staggered sink enables.
 assumes link pins are asynchronous to clk; comparator and thermal sense
 results arrive as asynchronous levels from the analog side.
*/
//
// Contract
// RULE_01 - top bit 0 routes low 24 bits to enable latch, 1 to control latch
// RULE_02 - chosen latch captures only on load strobe rising edge
// RULE_03 - each enable bit turns its sink on, subject to blanking
// RULE_04 - host writes both latches before enabling any output
// RULE_05 - control bits hold red, green, blue brightness in 7-bit fields
// RULE_06 - control bits 23..21 select open or short detect and threshold
// RULE_07 - group current scales linearly over 128 brightness steps
// RULE_08 - top bit 0 load copies enables then loads status word
// RULE_09 - top bit 1 load updates control latch only, no status
// RULE_10 - load without newly shifted data is ignored entirely
// RULE_11 - host refreshes status by reshifting same enable pattern
// RULE_12 - status bits leave serially one per shift clock rising edge
// RULE_13 - open mode reports low pin voltage on enabled outputs only
// RULE_14 - short mode reports high pin voltage on enabled outputs only
// RULE_15 - host keeps blanking low at least 1 us before raising it
// RULE_16 - detect holder freezes at blanking rise, transparent while low
// RULE_17 - load strobe moves detect and thermal holders into shift register
// RULE_18 - overheat forces outputs off, sets flag, restarts automatically
// RULE_19 - overheat flag held until load, then clears only if cooled
// RULE_20 - one detect type active; results invalid while overheat flag set
// RULE_21 - sinks switch in red0 green0 blue0 ... blue7 order with delay
// RULE_22 - blanking high forces every sink off
// RULE_23 - new brightness applies to current immediately
// RULE_24 - serial data shifts in msb first, oldest bit leaves on serial out
// RULE_25 - status word: detect bits in channel order low, flag on top
`timescale 1ns/1ps
module lsd_core
   import lsd_pkg::*;
(
   // system
   input wire logic clk,
   input wire logic rst_n,
   // serial link
   input wire logic shiftClk,
   input wire logic serialIn,
   input wire logic load_strobe,
   input wire logic blank,
   output logic serial_out,
   // analog sense, per channel in order r0 g0 b0 r1 ...
   input wire logic [CH_N-1:0] pinLow,
   input wire logic [CH_N-1:0] pinHigh,
   input wire logic overTemp,
   input wire logic belowRelease,
   // sink drive and brightness
   output logic [CH_N-1:0] sinkOn,
   output logic [BRIGHT_W-1:0] redBright,
   output logic [BRIGHT_W-1:0] greenBright,
   output logic [BRIGHT_W-1:0] blueBright,
   output logic [MODE_W-1:0] detectMode,
   output logic overheat_shutdown
);
   // ************************************************************
   // input synchronisers
   // ************************************************************
   logic [4:0] syncA_r;
   logic [4:0] syncB_r;
   logic [CH_N-1:0] lowA_r, lowB_r, highA_r, highB_r;
   logic sclkD_r, strobeD_r, blankD_r;
   always_ff @(posedge clk)
   begin
      syncA_r <= {shiftClk, serialIn, load_strobe, blank, overTemp};
      syncB_r <= syncA_r;
      lowA_r <= pinLow;
      lowB_r <= lowA_r;
      highA_r <= pinHigh;
      highB_r <= highA_r;
   end
   logic sclkS, sinS, strobeS, blankS, hotS;
   logic relA_r, relB_r;
   assign {sclkS, sinS, strobeS, blankS, hotS} = syncB_r;
   always_ff @(posedge clk)
   begin
      relA_r <= belowRelease;
      relB_r <= relA_r;
   end
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         sclkD_r <= 1'b0;
         strobeD_r <= 1'b0;
         blankD_r <= 1'b1;
      end
      else
      begin
         sclkD_r <= sclkS;
         strobeD_r <= strobeS;
         blankD_r <= blankS;
      end
   end
   logic sclkRise, strobeRise, blankRise, blankFall;
   assign sclkRise = sclkS & ~sclkD_r;
   assign strobeRise = strobeS & ~strobeD_r;
   assign blankRise = blankS & ~blankD_r;
   assign blankFall = ~blankS & blankD_r;

   // ************************************************************
   // shift register and latches
   // ************************************************************
   logic [SHIFT_W-1:0] shift_r;
   logic [CH_N-1:0] enLatch_r;
   logic [CH_N-1:0] ctrl_r;
   logic fresh_r;
   logic overheat_flag_r;
   logic [CH_N-1:0] detHold_r;
   logic loadOk;
   logic [CH_N-1:0] detLive;
   // RULE_10 load gating
   assign loadOk = strobeRise & fresh_r;
   // RULE_25 status word layout
   logic [SHIFT_W-1:0] status_word;
   assign status_word = {overheat_flag_r, detHold_r};

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         shift_r <= SHIFT_ZERO;
         fresh_r <= 1'b0;
      end
      // RULE_08 status replaces shift data after an enable load
      else if (loadOk && !shift_r[SEL_BIT])
      begin
         shift_r <= status_word;
         fresh_r <= 1'b0;
      end
      // RULE_24 msb-first shift
      else if (sclkRise)
      begin
         shift_r <= {shift_r[SHIFT_W-2:0], sinS};
         fresh_r <= 1'b1;
      end
      // RULE_09 control load leaves shift data alone
      else if (loadOk)
         fresh_r <= 1'b0;
   end

   // RULE_01 route by top bit
   // RULE_02 capture only on strobe rise
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         enLatch_r <= CH_ZERO;
      else if (loadOk && !shift_r[SEL_BIT])
         enLatch_r <= shift_r[CH_N-1:0];
   end
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         ctrl_r <= CH_ZERO;
      else if (loadOk && shift_r[SEL_BIT])
         ctrl_r <= shift_r[CH_N-1:0];
   end

   // RULE_12 oldest bit presented on serial out
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         serial_out <= 1'b0;
      else
         serial_out <= shift_r[SHIFT_W-1];
   end

   // ************************************************************
   // brightness and mode outputs
   // ************************************************************
   // RULE_05 field split
   // RULE_07 linear code passed to current dac
   // RULE_23 registered straight from latch, one cycle
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         redBright <= '0;
         greenBright <= '0;
         blueBright <= '0;
         detectMode <= '0;
      end
      else
      begin
         redBright <= ctrl_r[RED_LO +: BRIGHT_W];
         greenBright <= ctrl_r[GRN_LO +: BRIGHT_W];
         blueBright <= ctrl_r[BLU_LO +: BRIGHT_W];
         // RULE_06 mode code
         detectMode <= ctrl_r[MODE_LO +: MODE_W];
      end
   end

   // ************************************************************
   // fault detection and thermal holder
   // ************************************************************
   // RULE_13 open detect
   // RULE_14 short detect
   // RULE_20 single mode, masked by overheat
   assign detLive = overheat_flag_r ? CH_ZERO :
      (((ctrl_r[MODE_LO +: MODE_W] >= FIRST_SHORT_MODE) ? highB_r : lowB_r) & sinkOn);

   // RULE_16 transparent while blank low, frozen on rise
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         detHold_r <= CH_ZERO;
      else if (!blankS && !blankRise)
         detHold_r <= detLive;
   end

   // RULE_18 shutdown follows temperature with hysteresis
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         overheat_shutdown <= 1'b0;
      else if (hotS)
         overheat_shutdown <= 1'b1;
      else if (relB_r)
         overheat_shutdown <= 1'b0;
   end
   // RULE_19 flag set wins, clear only at load when cooled
   // RULE_17 flag sampled into status at load
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         overheat_flag_r <= 1'b0;
      else if (hotS)
         overheat_flag_r <= 1'b1;
      else if (loadOk && !shift_r[SEL_BIT] && relB_r)
         overheat_flag_r <= 1'b0;
   end

   // ************************************************************
   // staggered sink sequencer
   // ************************************************************
   logic [CH_N-1:0] target;
   logic [4:0] chIdx_r;
   logic [7:0] gap_r;
   logic busy_r;
   logic [CH_N-1:0] targetD_r;
   // RULE_22 blanking forces off
   // RULE_03 enable bit per sink
   assign target = (blankS || overheat_shutdown) ? CH_ZERO : enLatch_r;
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         targetD_r <= CH_ZERO;
      else
         targetD_r <= target;
   end

   // RULE_21 one channel per stagger step in fixed order
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         sinkOn <= CH_ZERO;
         chIdx_r <= '0;
         gap_r <= '0;
         busy_r <= 1'b0;
      end
      // a new wanted pattern restarts the pass, so red0 always switches first
      else if (target != targetD_r || blankFall || loadOk)
      begin
         busy_r <= 1'b1;
         chIdx_r <= '0;
         gap_r <= '0;
      end
      else if (!busy_r)
      begin
         if (target != sinkOn)
         begin
            busy_r <= 1'b1;
            chIdx_r <= '0;
            gap_r <= '0;
         end
      end
      else if (gap_r != 8'(STAGGER_CYC - 1))
         gap_r <= gap_r + 8'h01;
      else
      begin
         gap_r <= '0;
         sinkOn[chIdx_r] <= target[chIdx_r];
         if (chIdx_r == LAST_CH)
            busy_r <= 1'b0;
         else
            chIdx_r <= chIdx_r + 5'h01;
      end
   end

   // ************************************************************
   // assertions
   // ************************************************************
   sequence s_enLoad;
      loadOk && !shift_r[SEL_BIT];
   endsequence
   a_enable_capture: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
      s_enLoad |=> enLatch_r == $past(shift_r[CH_N-1:0]))
      else $error("enable latch missed load");
   a_latch_steady: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
      !loadOk |=> $stable(enLatch_r) && $stable(ctrl_r))
      else $error("latch changed without load");
   a_status_load: assert property (@(posedge clk) disable iff (!rst_n) // RULE_08
      s_enLoad |=> shift_r == $past(status_word))
      else $error("status word not loaded");
   a_ctrl_no_status: assert property (@(posedge clk) disable iff (!rst_n) // RULE_09
      (loadOk && shift_r[SEL_BIT] && !sclkRise) |=> $stable(shift_r))
      else $error("control load touched shift data");
   a_stale_ignored: assert property (@(posedge clk) disable iff (!rst_n) // RULE_10
      (strobeRise && !fresh_r && !sclkRise) |=> $stable(shift_r) && $stable(enLatch_r))
      else $error("stale load acted");
   a_shift_step: assert property (@(posedge clk) disable iff (!rst_n) // RULE_24
      (sclkRise && !loadOk) |=> shift_r == {$past(shift_r[SHIFT_W-2:0]), $past(sinS)})
      else $error("shift step wrong");
   a_blank_off: assert property (@(posedge clk) disable iff (!rst_n) // RULE_22
      blankS [*8] |-> ##[0:800] sinkOn == CH_ZERO || !blankS)
      else $error("sinks not off under blanking");
   a_hold_frozen: assert property (@(posedge clk) disable iff (!rst_n) // RULE_16
      (blankS && blankD_r) |=> $stable(detHold_r))
      else $error("holder moved while frozen");
   a_flag_held: assert property (@(posedge clk) disable iff (!rst_n) // RULE_19
      (overheat_flag_r && !(loadOk && !shift_r[SEL_BIT])) |=> overheat_flag_r)
      else $error("overheat flag dropped early");
   a_bright_follow: assert property (@(posedge clk) disable iff (!rst_n) // RULE_23
      (loadOk && shift_r[SEL_BIT]) |=> ##1 redBright == $past(shift_r[RED_LO +: BRIGHT_W], 2))
      else $error("brightness lagged");
endmodule // lsd_core

// ### logic/lsd_pkg.sv
/*
 package for the led sink latch block: field layout, widths and timing counts.
 assumes a 100 MHz system clock that samples the serial link pins.
*/
package lsd_pkg;
   localparam int SHIFT_W = 25;
   localparam int CH_N = 24;
   localparam int BRIGHT_W = 7;
   localparam int MODE_W = 3;
   localparam int SEL_BIT = 24;
   localparam int RED_LO = 0;
   localparam int GRN_LO = 7;
   localparam int BLU_LO = 14;
   localparam int MODE_LO = 21;
   localparam logic [2:0] FIRST_SHORT_MODE = 3'h4;
   // stagger between neighbouring channels
   localparam int STAGGER_NS = 30;
   localparam int CLK_PERIOD_NS = 10;
   localparam int STAGGER_CYC = (STAGGER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [4:0] LAST_CH = 5'h17;
   localparam logic [24:0] SHIFT_ZERO = 25'h0000000;
   localparam logic [23:0] CH_ZERO = 24'h000000;
endpackage

// ### bench/lsd_host_model.sv
/*
 host model on the led sink serial link: shift clock, data and load strobe.
 assumes clk is the 100 MHz bench clock; pins move at its falling edge.
*/
`timescale 1ns/1ps
module lsd_host_model
(
   // clock
   input wire logic clk,
   // link
   output logic shiftClk,
   output logic serialIn,
   output logic load_strobe,
   input wire logic serial_out
);
   // ***************
   // link tasks
   // ***************
   initial
   begin
      shiftClk = 1'b0;
      serialIn = 1'b0;
      load_strobe = 1'b0;
   end
   // 4 clk per half gives an 80 ns link clock
   task automatic half();
      repeat (4) @(negedge clk);
   endtask
   // msb first, read before each rise
   task automatic shift_word(input logic [24:0] w, output logic [24:0] rd);
      for (int i = 24; i >= 0; i--)
      begin
         serialIn = w[i];
         half();
         rd[i] = serial_out;
         shiftClk = 1'b1;
         half();
         shiftClk = 1'b0;
      end
      // idle data line shows the inverse, never a held bit
      serialIn = ~w[0];
   endtask
   task automatic pulse_load();
      half();
      load_strobe = 1'b1;
      half();
      load_strobe = 1'b0;
      half();
   endtask
endmodule // lsd_host_model

// ### bench/lsd_core_tb.sv
/*
 self-checking bench for lsd_core, host model on the link.
 assumes package and design files are compiled first.
*/
`timescale 1ns/1ps
module lsd_core_tb;
   import lsd_pkg::*;
   logic clk, rst_n, shiftClk, serialIn, load_strobe, blank, serial_out;
   logic overTemp, belowRelease, overheat_shutdown;
   logic [CH_N-1:0] pinLow, pinHigh, sinkOn;
   logic [BRIGHT_W-1:0] redBright, greenBright, blueBright;
   logic [MODE_W-1:0] detectMode;
   logic [24:0] got, ctrl;
   int err_count = 0;
   int compares = 0;
   int cycles = 0;
   localparam logic [23:0] EN = 24'h80f0c3;
   localparam logic [23:0] PL = 24'h00ff0f;
   localparam logic [23:0] PH = 24'h3c0f01;
   // ***************
   // harness
   // ***************
   lsd_core u_dut (.clk(clk), .rst_n(rst_n), .shiftClk(shiftClk), .serialIn(serialIn),
      .load_strobe(load_strobe), .blank(blank), .serial_out(serial_out),
      .pinLow(pinLow), .pinHigh(pinHigh), .overTemp(overTemp),
      .belowRelease(belowRelease), .sinkOn(sinkOn), .redBright(redBright),
      .greenBright(greenBright), .blueBright(blueBright), .detectMode(detectMode),
      .overheat_shutdown(overheat_shutdown));
   lsd_host_model u_host (.clk(clk), .shiftClk(shiftClk), .serialIn(serialIn),
      .load_strobe(load_strobe), .serial_out(serial_out));
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // run needs about 4200 clk
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 10000)
      begin
         err_count++;
         finish_test();
      end
   end
   task automatic finish_test();
      $display("errors %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [24:0] g, input logic [24:0] e);
      compares++;
      if (g !== e)
      begin
         err_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic xfer(input logic [24:0] w);
      u_host.shift_word(w, got);
      u_host.pulse_load();
   endtask
   // ***************
   // tests
   // ***************
   initial
   begin
      rst_n = 1'b0;
      blank = 1'b1;
      pinLow = PL;
      pinHigh = PH;
      overTemp = 1'b0;
      belowRelease = 1'b1;
      wt(8);
      rst_n = 1'b1;
      wt(4);
      for (int m = 0; m < 8; m++)
      begin
         xfer({1'b1, m[2:0], 7'h7f, 7'h2a, 7'h55});
         if (m > 0)
            chk(got, ctrl);
         ctrl = {1'b1, m[2:0], 7'h7f, 7'h2a, 7'h55};
         chk({1'b1, detectMode, blueBright, greenBright, redBright}, ctrl);
      end
      xfer({1'b0, EN});
      chk(got, ctrl);
      blank = 1'b0;
      wt(12);
      chk({sinkOn[23], sinkOn[0]}, 2'h1);
      wt(100);
      chk(sinkOn, EN);
      blank = 1'b1;
      wt(8);
      pinHigh = ~PH;
      wt(80);
      chk(sinkOn, 24'h0);
      xfer({1'b0, EN});
      blank = 1'b0;
      wt(100);
      u_host.pulse_load();
      blank = 1'b1;
      wt(8);
      xfer({1'b1, 3'h2, 7'h7f, 7'h2a, 7'h55});
      chk(got, {1'b0, PH & EN});
      blank = 1'b0;
      wt(100);
      blank = 1'b1;
      wt(8);
      xfer({1'b0, EN});
      xfer({1'b0, EN});
      chk(got, {1'b0, PL & EN});
      blank = 1'b0;
      overTemp = 1'b1;
      belowRelease = 1'b0;
      wt(20);
      chk({overheat_shutdown, sinkOn}, 25'h1000000);
      overTemp = 1'b0;
      xfer({1'b0, EN});
      belowRelease = 1'b1;
      wt(100);
      chk({overheat_shutdown, sinkOn}, {1'b0, EN});
      xfer({1'b0, EN});
      chk(got[24], 1'b1);
      xfer({1'b0, EN});
      u_host.shift_word({1'b0, EN}, got);
      chk(got[24], 1'b0);
      finish_test();
   end
endmodule // lsd_core_tb
